// file: logic/sadc_pkg.sv
// sadc_pkg: register map, field layout, reset values and conversion counts of the converter control block
`default_nettype none
package sadc_pkg;

  // ---------------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_ONE = 8'h1C;
  localparam logic [7:0] IDX_CONTROL_TWO = 8'h1D;
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h1E;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h1F;

  // ---------------------------------------------------------------------
  // adc_control_one fields
  // ---------------------------------------------------------------------
  localparam int unsigned C1_START_POS = 7;
  localparam int unsigned C1_MODE_POS  = 5;
  localparam int unsigned C1_GATE_POS  = 4;
  localparam int unsigned C1_CHAN_POS  = 0;
  localparam logic [7:0]  C1_RESET     = 8'h10;

  localparam logic [1:0] MODE_DISABLE  = 2'h0;
  localparam logic [1:0] MODE_SINGLE   = 2'h1;
  localparam logic [1:0] MODE_RESERVED = 2'h2;
  localparam logic [1:0] MODE_REPEAT   = 2'h3;
  localparam logic [3:0] CHAN_LAST     = 4'h7;

  // ---------------------------------------------------------------------
  // adc_control_two fields
  // ---------------------------------------------------------------------
  localparam int unsigned C2_LADDER_POS = 5;
  localparam int unsigned C2_FIXED1_POS = 4;
  localparam int unsigned C2_TIME_POS   = 1;
  localparam int unsigned C2_FIXED0_POS = 0;
  localparam logic [7:0]  C2_RESET      = 8'h10;

  // ---------------------------------------------------------------------
  // result_low_and_status fields
  // ---------------------------------------------------------------------
  localparam int unsigned ST_RES_POS  = 6;
  localparam int unsigned ST_DONE_POS = 5;
  localparam int unsigned ST_BUSY_POS = 4;

  // ---------------------------------------------------------------------
  // conversion time in oscillator periods; pclk is the oscillator clock
  // ---------------------------------------------------------------------
  localparam int unsigned CNT_W         = 11;
  localparam int unsigned PERIODS_T0    = 39;
  localparam int unsigned PERIODS_T2    = 78;
  localparam int unsigned PERIODS_T3    = 156;
  localparam int unsigned PERIODS_T4    = 312;
  localparam int unsigned PERIODS_T5    = 624;
  localparam int unsigned PERIODS_T6    = 1248;
  localparam logic [CNT_W-1:0] CYC_T0   = CNT_W'(PERIODS_T0);
  localparam logic [CNT_W-1:0] CYC_T2   = CNT_W'(PERIODS_T2);
  localparam logic [CNT_W-1:0] CYC_T3   = CNT_W'(PERIODS_T3);
  localparam logic [CNT_W-1:0] CYC_T4   = CNT_W'(PERIODS_T4);
  localparam logic [CNT_W-1:0] CYC_T5   = CNT_W'(PERIODS_T5);
  localparam logic [CNT_W-1:0] CYC_T6   = CNT_W'(PERIODS_T6);

endpackage
`default_nettype wire

// file: logic/sadc_tmr_if.sv
// sadc_tmr_if: handshake between the control logic and the conversion timer
`timescale 1ns/10ps
`default_nettype none
interface sadc_tmr_if;
  logic       start;
  logic       abort;
  logic [2:0] time_code;
  logic       done;
  logic       busy;

  modport ctrl  (output start, output abort, output time_code, input done, input busy);
  modport timer (input start, input abort, input time_code, output done, output busy);
endinterface
`default_nettype wire

// file: logic/sadc_timer.sv
// sadc_timer: counts oscillator cycles of one conversion
`timescale 1ns/10ps
`default_nettype none
module sadc_timer (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // control side
  sadc_tmr_if.timer   tmr
);

  typedef struct packed {
    logic                         busy;
    logic [sadc_pkg::CNT_W-1:0]   count;
    logic [sadc_pkg::CNT_W-1:0]   target;
  } sadc_tmr_state_t;

  sadc_tmr_state_t r;
  sadc_tmr_state_t n;

  // ---------------------------------------------------------------------
  // time code lookup
  // ---------------------------------------------------------------------
  function automatic logic [sadc_pkg::CNT_W-1:0] code_cycles(input logic [2:0] code);
    case (code)
      3'h0:    code_cycles = sadc_pkg::CYC_T0;
      3'h2:    code_cycles = sadc_pkg::CYC_T2;
      3'h3:    code_cycles = sadc_pkg::CYC_T3;
      3'h4:    code_cycles = sadc_pkg::CYC_T4;
      3'h5:    code_cycles = sadc_pkg::CYC_T5;
      3'h6:    code_cycles = sadc_pkg::CYC_T6;
      // reserved codes fall back to the longest time, the safe side
      default: code_cycles = sadc_pkg::CYC_T6;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------
  assign tmr.busy = r.busy;
  assign tmr.done = r.busy && !tmr.abort && (r.count == r.target - 11'h001);

  always_comb begin
    n = r;
    if (tmr.abort) begin
      n.busy  = 1'b0;
      n.count = '0;
    end else if (tmr.start && (!r.busy || tmr.done)) begin
      n.busy   = 1'b1;
      n.count  = '0;
      n.target = code_cycles(tmr.time_code);
    end else if (tmr.done) begin
      n.busy  = 1'b0;
      n.count = '0;
    end else if (r.busy) begin
      n.count = r.count + 11'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule
`default_nettype wire

// file: logic/sadc_ctrl.sv
// sadc_ctrl: register file, apb slave and conversion sequencing of the sar converter
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - mode field 00 disables, 01 single software start, 10 reserved, 11 repeat.
// - channel codes 0 to 7 select inputs 0 to 7; higher codes reserved.
// - analog inputs enabled when gate bit is 0, disabled when 1.
// - in single mode writing start bit 1 begins converting selected channel.
// - start bit clears itself once the conversion has begun.
// - on completion store result, set done flag and raise completion interrupt together.
// - standby resets both control registers and ignores writes until normal mode.
// - ladder connected only while converting if bit 0, always if bit 1.
// - time code selects 39 to 1248 oscillator periods; 001 and 111 reserved.
// - reading control two returns bits 6 and 7 undefined.
// - result 9..2 in high register, result 1..0 in bits 7..6 of low.
// - reading the high result register clears the done flag.
// - busy set at start, cleared at finish and on entering standby.
// - status bits 3..0 read meaningless; done and busy are read only.
// - repeat mode restarts after each completion; mode 00 halts at once, no store.
// - new start before result read clears done, old result kept until completion.
module sadc_ctrl (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [sadc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [sadc_pkg::DATA_W-1:0]   pwdata,
  output logic                               pready,
  output logic [sadc_pkg::DATA_W-1:0]        prdata,
  output logic                               pslverr,
  // power mode
  input  wire logic                          standby_active,
  // analog front end
  input  wire logic [9:0]                    analog_result,
  output logic [2:0]                         channel_select,
  output logic                               channel_valid,
  output logic                               analog_input_enable,
  output logic                               ladder_connect,
  output logic                               sample_start,
  output logic                               converter_busy_flag,
  // event
  output logic                               conversion_complete_irq
);

  typedef struct packed {
    logic                         start_trigger_bit;
    logic [1:0]                   operating_mode_field;
    logic                         analog_input_gate;
    logic [3:0]                   channel_select;
    logic                         ladder_connect_control;
    logic                         fixed_one;
    logic [2:0]                   time_code;
    logic                         fixed_zero;
    logic [9:0]                   result;
    logic                         conversion_done_flag;
    logic [sadc_pkg::DATA_W-1:0]  rdata;
    logic                         slverr;
    logic                         irq;
  } sadc_ctrl_state_t;

  sadc_ctrl_state_t r;
  sadc_ctrl_state_t n;
  sadc_tmr_if       tmr ();

  // ---------------------------------------------------------------------
  // conversion timer
  // ---------------------------------------------------------------------
  sadc_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tmr     (tmr)
  );

  // ---------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------
  function automatic logic addr_is(input logic [sadc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a == {idx, 2'h0});
  endfunction

  logic sel_c1;
  logic sel_c2;
  logic sel_lo;
  logic sel_hi;
  logic mapped;
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic mode_runs;
  logic chan_ok;
  logic start_fire;
  logic repeat_again;
  logic halt;

  assign sel_c1   = addr_is(paddr, sadc_pkg::IDX_CONTROL_ONE);
  assign sel_c2   = addr_is(paddr, sadc_pkg::IDX_CONTROL_TWO);
  assign sel_lo   = addr_is(paddr, sadc_pkg::IDX_RESULT_LOW);
  assign sel_hi   = addr_is(paddr, sadc_pkg::IDX_RESULT_HIGH);
  assign mapped   = sel_c1 | sel_c2 | sel_lo | sel_hi;
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;

  // ---------------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------------
  assign mode_runs = (r.operating_mode_field == sadc_pkg::MODE_SINGLE) ||
                     (r.operating_mode_field == sadc_pkg::MODE_REPEAT);
  assign chan_ok   = (r.channel_select <= sadc_pkg::CHAN_LAST);
  assign start_fire = r.start_trigger_bit && mode_runs && chan_ok && !tmr.busy && !standby_active;
  assign repeat_again = tmr.done && (r.operating_mode_field == sadc_pkg::MODE_REPEAT) && chan_ok;
  // reserved mode 10 halts like disable, so a running conversion never hangs
  assign halt = tmr.busy && (standby_active || !mode_runs);

  assign tmr.start     = start_fire || repeat_again;
  assign tmr.abort     = halt;
  assign tmr.time_code = r.time_code;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    n     = r;
    n.irq = 1'b0;

    // register writes, locked out during standby
    if (wr_acc && !standby_active && sel_c1) begin
      n.start_trigger_bit    = pwdata[sadc_pkg::C1_START_POS];
      n.operating_mode_field = pwdata[sadc_pkg::C1_MODE_POS +: 2];
      n.analog_input_gate    = pwdata[sadc_pkg::C1_GATE_POS];
      n.channel_select       = pwdata[sadc_pkg::C1_CHAN_POS +: 4];
    end
    if (wr_acc && !standby_active && sel_c2) begin
      n.ladder_connect_control = pwdata[sadc_pkg::C2_LADDER_POS];
      n.fixed_one              = pwdata[sadc_pkg::C2_FIXED1_POS];
      n.time_code              = pwdata[sadc_pkg::C2_TIME_POS +: 3];
      n.fixed_zero             = pwdata[sadc_pkg::C2_FIXED0_POS];
    end

    // start bit is consumed on begin, or dropped if it can never fire
    if (start_fire) begin
      n.start_trigger_bit    = 1'b0;
      n.conversion_done_flag = 1'b0;
    end else if (r.start_trigger_bit && !tmr.busy && !(mode_runs && chan_ok)) begin
      n.start_trigger_bit = 1'b0;
    end

    // reading the high byte consumes the done flag
    if (rd_acc && sel_hi) begin
      n.conversion_done_flag = 1'b0;
    end

    // completion wins over any clear in the same cycle
    if (tmr.done) begin
      n.result               = analog_result;
      n.conversion_done_flag = 1'b1;
      n.irq                  = 1'b1;
    end

    // standby puts control back to reset and discards the result
    if (standby_active) begin
      n.start_trigger_bit      = sadc_pkg::C1_RESET[sadc_pkg::C1_START_POS];
      n.operating_mode_field   = sadc_pkg::C1_RESET[sadc_pkg::C1_MODE_POS +: 2];
      n.analog_input_gate      = sadc_pkg::C1_RESET[sadc_pkg::C1_GATE_POS];
      n.channel_select         = sadc_pkg::C1_RESET[sadc_pkg::C1_CHAN_POS +: 4];
      n.ladder_connect_control = sadc_pkg::C2_RESET[sadc_pkg::C2_LADDER_POS];
      n.fixed_one              = sadc_pkg::C2_RESET[sadc_pkg::C2_FIXED1_POS];
      n.time_code              = sadc_pkg::C2_RESET[sadc_pkg::C2_TIME_POS +: 3];
      n.fixed_zero             = sadc_pkg::C2_RESET[sadc_pkg::C2_FIXED0_POS];
      n.result                 = '0;
      n.conversion_done_flag   = 1'b0;
      n.irq                    = 1'b0;
    end

    // read data is latched in the setup cycle, so prdata comes from a flop
    if (setup_ph) begin
      n.rdata  = '0;
      n.slverr = !mapped;
      if (sel_c1) begin
        n.rdata[7:0] = {r.start_trigger_bit, r.operating_mode_field, r.analog_input_gate, r.channel_select};
      end
      if (sel_c2) begin
        // undefined top bits are given as zero
        n.rdata[7:0] = {2'h0, r.ladder_connect_control, r.fixed_one, r.time_code, r.fixed_zero};
      end
      if (sel_lo) begin
        // meaningless low nibble is given as zero
        n.rdata[7:0] = {r.result[1:0], r.conversion_done_flag, tmr.busy, 4'h0};
      end
      if (sel_hi) begin
        n.rdata[7:0] = r.result[9:2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r                        <= '0;
      r.analog_input_gate      <= sadc_pkg::C1_RESET[sadc_pkg::C1_GATE_POS];
      r.fixed_one              <= sadc_pkg::C2_RESET[sadc_pkg::C2_FIXED1_POS];
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign pready                  = 1'b1;
  assign prdata                  = r.rdata;
  assign pslverr                 = r.slverr;
  assign channel_select          = r.channel_select[2:0];
  assign channel_valid           = chan_ok;
  assign analog_input_enable     = !r.analog_input_gate;
  assign ladder_connect          = r.ladder_connect_control || tmr.busy;
  assign sample_start            = tmr.start && !halt;
  assign converter_busy_flag     = tmr.busy;
  assign conversion_complete_irq = r.irq;

endmodule
`default_nettype wire

// file: testbench/sadc_afe_model.sv
// sadc_afe_model: behavioural analog front end returning a channel-tagged sample
`timescale 1ns/10ps
`default_nettype none
module sadc_afe_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // converter side
  input  wire logic [2:0] channel_select,
  input  wire logic       analog_input_enable,
  input  wire logic       sample_start,
  input  wire logic       converter_busy_flag,
  output logic      [9:0] analog_result
);
  // ---------------------------------
  // sample store
  // ---------------------------------
  logic [6:0] num_reg;
  logic [9:0] hold_reg;
  // toggles while idle so a stale sample never passes for a fresh one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      num_reg  <= 7'h00;
      hold_reg <= 10'h000;
    end else if (sample_start) begin
      num_reg  <= num_reg + 7'h01;
      hold_reg <= {channel_select, num_reg};
    end else if (!converter_busy_flag) begin
      hold_reg <= ~hold_reg;
    end
  end
  // a disabled input yields a wrong value on purpose
  assign analog_result = analog_input_enable ? hold_reg : ~hold_reg;
endmodule
`default_nettype wire

// file: testbench/sadc_ctrl_assertions.sv
// sadc_ctrl_assertions: port-level checks of the converter control block
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // power and converter
  input wire logic standby_active,
  input wire logic channel_valid,
  input wire logic analog_input_enable,
  input wire logic ladder_connect,
  input wire logic sample_start,
  input wire logic converter_busy_flag,
  input wire logic conversion_complete_irq
);
  // ---------------------------------
  // checks
  // ---------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_start_busy: assert property (sample_start && !standby_active |=> converter_busy_flag)
    else $error("busy missing after start");
  chk_busy_cause: assert property ($rose(converter_busy_flag) |-> $past(sample_start))
    else $error("busy rose without start");
  chk_start_clear: assert property (sample_start |=> !sample_start)
    else $error("start pulse repeated");
  chk_irq_pulse: assert property (conversion_complete_irq |=> !conversion_complete_irq)
    else $error("irq longer than one cycle");
  chk_irq_cause: assert property (conversion_complete_irq |-> $past(converter_busy_flag))
    else $error("irq without conversion");
  chk_no_early_irq: assert property ($rose(converter_busy_flag) |-> !conversion_complete_irq [*8])
    else $error("irq too soon after start");
  chk_ladder_busy: assert property (converter_busy_flag |-> ladder_connect)
    else $error("ladder open during conversion");
  chk_start_valid: assert property (sample_start |-> channel_valid)
    else $error("start on reserved channel");
  chk_standby_idle: assert property (standby_active |=> !converter_busy_flag && !ladder_connect && !analog_input_enable)
    else $error("standby left converter active");
  cover property (conversion_complete_irq);
  cover property (standby_active && converter_busy_flag);
  cover property ($fell(converter_busy_flag) && !conversion_complete_irq);
endmodule
bind sadc_ctrl sadc_ctrl_assertions i_chk (.pclk, .presetn, .standby_active, .channel_valid,
  .analog_input_enable, .ladder_connect, .sample_start, .converter_busy_flag, .conversion_complete_irq);
`default_nettype wire

// file: testbench/tb_sadc_ctrl.sv
// tb_sadc_ctrl: self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_sadc_ctrl;
  // ---------------------------------
  // signals and tables
  // ---------------------------------
  localparam logic [9:0] A1 = {sadc_pkg::IDX_CONTROL_ONE, 2'h0};
  localparam logic [9:0] A2 = {sadc_pkg::IDX_CONTROL_TWO, 2'h0};
  localparam logic [9:0] A3 = {sadc_pkg::IDX_RESULT_LOW, 2'h0};
  localparam logic [9:0] A4 = {sadc_pkg::IDX_RESULT_HIGH, 2'h0};
  logic [9:0]  adr_tab [5] = '{A1, A2, A3, A4, 10'h080};
  logic [31:0] msk_tab [5] = '{32'hFF, 32'h3F, 32'hF0, 32'hFF, 32'hFFFFFFFF};
  logic [7:0]  rst_tab [5] = '{sadc_pkg::C1_RESET, sadc_pkg::C2_RESET, 8'h00, 8'h00, 8'h00};
  logic [1:0]  bad_m [4]   = '{sadc_pkg::MODE_DISABLE, sadc_pkg::MODE_RESERVED, 2'h1, 2'h1};
  logic [3:0]  bad_c [4]   = '{4'h3, 4'h3, 4'h8, 4'hF};
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        standby_active = 1'h0, pready, pslverr, err, channel_valid, analog_input_enable;
  logic        ladder_connect, sample_start, converter_busy_flag, conversion_complete_irq;
  logic [9:0]  paddr = 10'h000, analog_result, ra, rb;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hD0B581E1;
  logic [2:0]  channel_select;
  logic [6:0]  nconv = 7'h00;
  int          mismatches = 0, num_checks = 0, irqs = 0, len, k;
  sadc_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .standby_active, .analog_result, .channel_select, .channel_valid, .analog_input_enable, .ladder_connect,
    .sample_start, .converter_busy_flag, .conversion_complete_irq);
  sadc_afe_model i_afe (.pclk, .presetn, .channel_select, .analog_input_enable, .sample_start,
    .converter_busy_flag, .analog_result);
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (conversion_complete_irq === 1'h1) irqs <= irqs + 1;
  // ---------------------------------
  // expectations and bus tasks
  // ---------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_len(input logic [2:0] c);
    case (c)
      3'h0: return sadc_pkg::PERIODS_T0;
      3'h2: return sadc_pkg::PERIODS_T2;
      3'h3: return sadc_pkg::PERIODS_T3;
      3'h4: return sadc_pkg::PERIODS_T4;
      3'h5: return sadc_pkg::PERIODS_T5;
      default: return sadc_pkg::PERIODS_T6;
    endcase
  endfunction
  function automatic logic [7:0] stat(input logic [9:0] r, input logic d, input logic b);
    return {r[1:0], d, b, 4'h0};
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic expire;
    $display("Error at %0t: wait bound used up, got %0h expected %0h", $time, 0, 1);
    mismatches++;
    end_sim();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  // holds the whole request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) expire();
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic go(input logic [2:0] c, input logic [3:0] ch, input logic [1:0] m, input logic lad);
    apb(1'h1, A2, {26'h0, lad, 1'h1, c, 1'h0});
    apb(1'h1, A1, {24'h0, 1'h1, m, 1'h0, ch});
  endtask
  // counts busy cycles; a busy already running is counted from here
  task automatic run(output int n);
    int w;
    w = 0;
    n = 0;
    while (converter_busy_flag !== 1'h1 && w < 20) begin
      @(posedge pclk);
      w++;
    end
    while (converter_busy_flag === 1'h1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (w >= 20 || n >= 3000) expire();
  endtask
  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      rdchk(adr_tab[i], msk_tab[i], rst_tab[i]);
      chk(err, i == 4); // unmapped place answers with an error
    end
    apb(1'h1, A3, seed);
    apb(1'h1, A4, seed);
    rdchk(A3, 32'hF0, 32'h0);
    rdchk(A4, 32'hFF, 32'h0);
    $display("test reset and access done");
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      ra = {seed[2:0], nconv};
      nconv++;
      go(3'(c), {1'h0, seed[2:0]}, sadc_pkg::MODE_SINGLE, seed[8]);
      run(len);
      chk(len, exp_len(3'(c)));
      chk(channel_select, seed[2:0]);
      chk(analog_input_enable, 1'h1);
      chk(ladder_connect, seed[8]);
      rdchk(A3, 32'hF0, stat(ra, 1'h1, 1'h0));
      rdchk(A4, 32'hFF, ra[9:2]);
      rdchk(A3, 32'h30, 32'h0);
      rdchk(A1, 32'hFF, {1'h0, sadc_pkg::MODE_SINGLE, 5'(seed[2:0])});
      chk(irqs, c + 1);
    end
    $display("test time codes done");
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, A1, {24'h0, 1'h1, bad_m[i], 1'h0, bad_c[i]});
      repeat (3) @(posedge pclk);
      chk(converter_busy_flag, 1'h0);
      chk(channel_valid, bad_c[i] <= sadc_pkg::CHAN_LAST);
      rdchk(A1, 32'hFF, {1'h0, bad_m[i], 1'h0, bad_c[i]});
    end
    $display("test refused starts done");
    ra = {3'h6, nconv};
    rb = {3'h1, nconv + 7'h01};
    nconv = nconv + 7'h02;
    go(3'h0, 4'h6, sadc_pkg::MODE_SINGLE, 1'h0);
    run(len);
    go(3'h0, 4'h1, sadc_pkg::MODE_SINGLE, 1'h0);
    rdchk(A3, 32'hF0, stat(ra, 1'h0, 1'h1));
    rdchk(A4, 32'hFF, ra[9:2]);
    run(len);
    rdchk(A3, 32'hF0, stat(rb, 1'h1, 1'h0));
    rdchk(A4, 32'hFF, rb[9:2]);
    $display("test retrigger done");
    k = irqs;
    go(3'h0, 4'h5, sadc_pkg::MODE_REPEAT, 1'h0);
    for (int j = 0; j < 400 && irqs < k + 3; j++) @(posedge pclk);
    chk(irqs, k + 3);
    chk(converter_busy_flag, 1'h1);
    apb(1'h1, A1, {24'h0, 1'h0, sadc_pkg::MODE_DISABLE, 1'h0, 4'h5});
    k = irqs;
    repeat (50) @(posedge pclk);
    chk(converter_busy_flag, 1'h0);
    chk(irqs, k);
    rdchk(A3, 32'h30, 32'h20);
    $display("test repeat done");
    k = irqs;
    go(3'h6, 4'h2, sadc_pkg::MODE_SINGLE, 1'h1);
    apb(1'h1, A1, {24'h0, 1'h0, sadc_pkg::MODE_SINGLE, 1'h1, 4'h2});
    // the write lands at the access edge, so look one edge later
    @(posedge pclk);
    chk(analog_input_enable, 1'h0);
    standby_active <= 1'h1;
    repeat (3) @(posedge pclk);
    chk(converter_busy_flag, 1'h0);
    apb(1'h1, A1, 32'h25);
    apb(1'h1, A2, 32'h3E);
    rdchk(A1, 32'hFF, sadc_pkg::C1_RESET);
    rdchk(A2, 32'h3F, sadc_pkg::C2_RESET);
    standby_active <= 1'h0;
    rdchk(A1, 32'hFF, sadc_pkg::C1_RESET);
    rdchk(A3, 32'hF0, 32'h0);
    chk(irqs, k);
    $display("test standby done");
    end_sim();
  end
endmodule
`default_nettype wire
